// ==== hw/fid_device.sv ====
// flash device end: command decode, id and table readout, deep sleep
`timescale 1ns/100ps
`include "fid_params.svh"
module fid_device
	import fid_pkg::*;
#(
	parameter int REL_CYC = `FID_REL_CYC,
	parameter int BUSY_CYC = `FID_BUSY_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	fid_link_if.dev link,
	input wire logic freeze_in,
	input wire logic guard_lock_in,
	output logic write_in_progress,
	output logic deep_sleep,
	output logic four_line_mode,
	output logic xip_mode,
	output logic freeze,
	output logic sector_guard_lock
);
	localparam int AW = $clog2(`FID_MEM_BYTES);
	logic [2:0] cs_s, sck_s;
	logic [3:0] io1_q, io2_q;
	logic [7:0] mem_q [`FID_MEM_BYTES];
	fid_dev_st_t st_q;
	logic [7:0] op_q, sh_q, cur_q;
	logic [4:0] bcnt_q;
	logic [23:0] addr_q;
	logic [AW-1:0] ptr_q;
	logic [9:0] nbytes_q;
	logic wel_q, rst_en_q, table_q;
	logic [15:0] busy_q, rel_q;
	logic [1:0] job_q;
	logic [7:0] base_q;
	logic [3:0] dout_q;
	logic doe_q;
	logic pend_sleep_q;
	wire cs_act = !cs_s[1];
	wire rise = sck_s[1] && !sck_s[2];
	wire fall = !sck_s[1] && sck_s[2];
	wire cs_up = cs_s[1] && !cs_s[2];
	wire [2:0] step = four_line_mode ? 3'd4 : 3'd1;
	wire [7:0] sh_in = four_line_mode ? {sh_q[3:0], io2_q} : {sh_q[6:0], io2_q[0]};
	wire byte_done = (bcnt_q + {2'b00, step}) >= 5'd8;
	// fixed identity and table content; values are arbitrary
	function automatic logic [7:0] rom_byte(input logic tbl, input logic [7:0] a);
		rom_byte = tbl ? (`FID_TBL_KEY ^ a) : (a == 8'h00 ? `FID_ID_FIRST : (`FID_ID_BASE + a));
	endfunction : rom_byte
	// pins are outside the clock domain: two stages before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_s <= 3'h7;
			sck_s <= 3'h0;
			io1_q <= 4'hF;
			io2_q <= 4'hF;
		end else if (clk_en) begin
			cs_s <= {cs_s[1:0], link.cs_n};
			sck_s <= {sck_s[1:0], link.sck};
			io1_q <= link.io;
			io2_q <= io1_q;
		end
	end
	// command sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= FID_S_OP;
			op_q <= 8'h00;
			sh_q <= 8'h00;
			bcnt_q <= 5'h00;
			addr_q <= 24'h000000;
			nbytes_q <= 10'h000;
			wel_q <= 1'b0;
			rst_en_q <= 1'b0;
			four_line_mode <= 1'b0;
			xip_mode <= 1'b0;
			deep_sleep <= 1'b0;
			pend_sleep_q <= 1'b0;
			rel_q <= 16'h0000;
			busy_q <= 16'h0000;
			job_q <= 2'h0;
			base_q <= 8'h00;
			table_q <= 1'b0;
			ptr_q <= '0;
			cur_q <= 8'h00;
			dout_q <= 4'h0;
			doe_q <= 1'b0;
			freeze <= 1'b0;
			sector_guard_lock <= 1'b0;
			for (int k = 0; k < `FID_MEM_BYTES; k++) mem_q[k] <= 8'hFF;
		end else if (clk_en) begin
			if (freeze_in) freeze <= 1'b1;
			if (guard_lock_in) sector_guard_lock <= 1'b1;
			// release delay counts down to standby
			if (rel_q != 16'h0000) begin
				rel_q <= rel_q - 16'h0001;
				if (rel_q == 16'h0001) deep_sleep <= 1'b0;
			end
			// embedded operation: erase applies at its end
			if (busy_q != 16'h0000) begin
				busy_q <= busy_q - 16'h0001;
				if (busy_q == 16'h0001 && job_q != 2'h0) begin
					for (int k = 0; k < `FID_MEM_BYTES; k++)
						if (job_q == 2'h2 || k[7:0] / `FID_SECT_BYTES == base_q / `FID_SECT_BYTES)
							mem_q[k] <= 8'hFF;
					job_q <= 2'h0;
				end
			end
			if (!cs_act) begin
				// abandon partial reads, start queued operations at deselect
				st_q <= FID_S_OP;
				bcnt_q <= 5'h00;
				doe_q <= 1'b0;
				if (cs_up && st_q == FID_S_DATA && nbytes_q != 10'h000) begin
					busy_q <= BUSY_CYC[15:0];
					wel_q <= 1'b0;
				end
				if (cs_up && pend_sleep_q) deep_sleep <= 1'b1;
				pend_sleep_q <= 1'b0;
			end else if (rise) begin
				sh_q <= sh_in;
				bcnt_q <= byte_done ? 5'h00 : bcnt_q + {2'b00, step};
				case (st_q)
				FID_S_OP: begin
					if (byte_done) begin
						op_q <= sh_in;
						st_q <= FID_S_SKIP;
						if (deep_sleep) begin
							if (sh_in == `FID_OP_WAKE) rel_q <= REL_CYC[15:0];
						end else begin
							rst_en_q <= (sh_in == `FID_OP_RSTEN);
							case (sh_in)
							`FID_OP_WR_ON: wel_q <= 1'b1;
							`FID_OP_SLEEP: pend_sleep_q <= !write_in_progress;
							`FID_OP_MBR: xip_mode <= 1'b0;
							`FID_OP_QPIEN: four_line_mode <= 1'b1;
							`FID_OP_QPIEX: four_line_mode <= 1'b0;
							`FID_OP_RST: if (rst_en_q) begin
								// soft reset: freeze and guard lock kept
								four_line_mode <= 1'b0;
								xip_mode <= 1'b0;
								wel_q <= 1'b0;
								busy_q <= 16'h0000;
								job_q <= 2'h0;
							end
							`FID_OP_IDENT, `FID_OP_QIDENT: begin
								// quad variant only in four-line mode, none while busy
								if (!write_in_progress && (sh_in == `FID_OP_IDENT || four_line_mode)) begin
									st_q <= FID_S_OUT;
									table_q <= 1'b0;
									ptr_q <= '0;
									cur_q <= rom_byte(1'b0, 8'h00);
								end
							end
							`FID_OP_SFDP: if (!write_in_progress) begin
								st_q <= FID_S_ADDR;
								table_q <= 1'b1;
							end
							`FID_OP_PROG, `FID_OP_SE, `FID_OP_BE:
								if (wel_q && !write_in_progress) st_q <= (sh_in == `FID_OP_BE) ? FID_S_SKIP : FID_S_ADDR;
							default: ;
							endcase
							if (sh_in == `FID_OP_BE && wel_q && !write_in_progress) begin
								job_q <= 2'h2;
								busy_q <= BUSY_CYC[15:0];
								wel_q <= 1'b0;
							end
						end
					end
				end
				FID_S_ADDR: begin
					addr_q <= four_line_mode ? {addr_q[19:0], io2_q} : {addr_q[22:0], io2_q[0]};
					if (byte_done) nbytes_q <= nbytes_q + 10'h001;
					if (byte_done && nbytes_q == 10'h002) begin
						nbytes_q <= 10'h000;
						ptr_q <= sh_in[AW-1:0];
						if (op_q == `FID_OP_SFDP) begin
							st_q <= FID_S_DUMMY;
							cur_q <= rom_byte(1'b1, sh_in);
						end else if (op_q == `FID_OP_SE) begin
							st_q <= FID_S_SKIP;
							job_q <= 2'h1;
							base_q <= sh_in;
							busy_q <= BUSY_CYC[15:0];
							wel_q <= 1'b0;
						end else st_q <= FID_S_DATA;
					end
				end
				FID_S_DUMMY: begin
					nbytes_q <= nbytes_q + 10'h001;
					if (nbytes_q == `FID_DUMMY_CYC - 1) begin
						nbytes_q <= 10'h000;
						bcnt_q <= 5'h00;
						st_q <= FID_S_OUT;
					end
				end
				FID_S_DATA: if (byte_done && nbytes_q < `FID_PAGE_SIZE) begin
					mem_q[ptr_q] <= mem_q[ptr_q] & sh_in;
					ptr_q <= ptr_q + 1'b1;
					nbytes_q <= nbytes_q + 10'h001;
				end
				FID_S_OUT: if (byte_done) begin
					ptr_q <= ptr_q + 1'b1;
					cur_q <= rom_byte(table_q, 8'(ptr_q + 1'b1));
				end
				default: ;
				endcase
			end else if (fall && st_q == FID_S_OUT) begin
				// output msb first, all four lines in quad mode, io[1] only in single-line mode
				doe_q <= 1'b1;
				dout_q <= four_line_mode ? (bcnt_q[2] ? cur_q[3:0] : cur_q[7:4])
					: {2'b00, cur_q[3'd7 - bcnt_q[2:0]], 1'b0};
			end
		end
	end
	assign write_in_progress = (busy_q != 16'h0000);
	assign link.d_io_o = dout_q;
	assign link.d_io_oe_n = !doe_q ? 4'hF : (four_line_mode ? 4'h0 : 4'hD);
endmodule : fid_device

// ==== hw/fid_host.sv ====
// host controller end: APB registers drive one command on the link
`timescale 1ns/100ps
`include "fid_params.svh"
module fid_host
	import fid_pkg::*;
#(
	parameter int DIV = `FID_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	fid_link_if.host link
);
	// regs: 0x00 ctrl {quad[9],go[8],op}, 0x04 tx word, 0x08 counts, 0x0C rx, 0x10 status
	fid_host_st_t st_q;
	logic [7:0] op_q, ntx_q, nrx_q, cnt_q, div_q;
	logic [31:0] tx_q, rx_q, sh_q;
	logic quad_q, sck_q, cs_q;
	logic [3:0] rx1_q, rx2_q;
	wire acc = psel && penable;
	wire hit = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
	wire tick = div_q == 8'(DIV - 1);
	wire [7:0] step = quad_q ? 8'd4 : 8'd1;
	assign pready = 1'b1;
	assign pslverr = acc && !hit;
	// register read mux
	always_comb begin
		case (paddr[4:2])
		3'h0: prdata = {22'h0, quad_q, 1'b0, op_q};
		3'h1: prdata = tx_q;
		3'h2: prdata = {16'h0, nrx_q, ntx_q};
		3'h3: prdata = rx_q;
		3'h4: prdata = {31'h0, st_q != FID_H_IDLE};
		default: prdata = 32'h0;
		endcase
	end
	// returning lines are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx1_q <= 4'hF;
			rx2_q <= 4'hF;
		end else if (clk_en) begin
			rx1_q <= link.io;
			rx2_q <= rx1_q;
		end
	end
	// sequencer: ntx bits out (op first, msb first), then nrx bits in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= FID_H_IDLE;
			op_q <= 8'h00;
			ntx_q <= 8'h00;
			nrx_q <= 8'h00;
			tx_q <= 32'h0;
			rx_q <= 32'h0;
			sh_q <= 32'h0;
			quad_q <= 1'b0;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			cnt_q <= 8'h00;
			div_q <= 8'h00;
		end else if (clk_en) begin
			div_q <= tick ? 8'h00 : div_q + 8'h01;
			// an address above 0x1C or unaligned answers with an error and writes nothing; 0x14-0x1C pass without error
			if (acc && pwrite && hit && st_q == FID_H_IDLE) begin
				if (paddr[4:0] == 5'h04) tx_q <= pwdata;
				if (paddr[4:0] == 5'h08) {nrx_q, ntx_q} <= pwdata[15:0];
				if (paddr[4:0] == 5'h00) begin
					op_q <= pwdata[7:0];
					quad_q <= pwdata[9];
					if (pwdata[8]) begin
						st_q <= FID_H_SEND;
						cs_q <= 1'b0;
						cnt_q <= 8'h00;
						sh_q <= {pwdata[7:0], tx_q[31:8]};
					end
				end
			end
			if (tick) begin
				case (st_q)
				FID_H_SEND, FID_H_RECV: begin
					sck_q <= !sck_q;
					if (sck_q) begin
						cnt_q <= cnt_q + step;
						if (st_q == FID_H_SEND) sh_q <= quad_q ? sh_q << 4 : sh_q << 1;
						// sample late, just before the fall, msb first: the answer to a fall
						// passes two sync stages each way, more than half an sck period
						if (st_q == FID_H_RECV) begin
							rx_q <= quad_q ? {rx_q[27:0], rx2_q} : {rx_q[30:0], rx2_q[1]};
						end
						if (st_q == FID_H_SEND && cnt_q + step >= ntx_q) begin
							st_q <= nrx_q == 8'h00 ? FID_H_WAIT : FID_H_RECV;
							cnt_q <= 8'h00;
						end else if (st_q == FID_H_RECV && cnt_q + step >= nrx_q) st_q <= FID_H_WAIT;
					end
				end
				FID_H_WAIT: begin
					cs_q <= 1'b1;
					st_q <= FID_H_DONE;
				end
				FID_H_DONE: st_q <= FID_H_IDLE;
				default: ;
				endcase
			end
		end
	end
	assign link.cs_n = cs_q;
	assign link.sck = sck_q;
	assign link.h_io_o = quad_q ? sh_q[31:28] : {3'b111, sh_q[31]};
	assign link.h_io_oe_n = st_q != FID_H_SEND ? 4'hF : (quad_q ? 4'h0 : 4'hE);
endmodule : fid_host

// ==== hw/fid_link_if.sv ====
// serial link between host controller and flash device
`timescale 1ns/100ps
interface fid_link_if;
	logic cs_n;
	logic sck;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe_n;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe_n;
	wire [3:0] io;
	genvar i;
	// each line is the driver whose enable is low, else pulled high
	for (i = 0; i < 4; i++) begin : g_io
		assign io[i] = !h_io_oe_n[i] ? h_io_o[i] : (!d_io_oe_n[i] ? d_io_o[i] : 1'b1);
	end
	modport host (output cs_n, output sck, output h_io_o, output h_io_oe_n, input io);
	modport dev (input cs_n, input sck, output d_io_o, output d_io_oe_n, input io);
endinterface : fid_link_if

// ==== hw/fid_params.svh ====
// constants for the flash identification and power-down command block
`ifndef FID_PARAMS_SVH
`define FID_PARAMS_SVH
`define FID_OP_WR_ON 8'h06
`define FID_OP_PROG 8'h02
`define FID_OP_SE 8'hD8
`define FID_OP_BE 8'h60
`define FID_OP_IDENT 8'h9F
`define FID_OP_QIDENT 8'hAF
`define FID_OP_SFDP 8'h5A
`define FID_OP_SLEEP 8'hB9
`define FID_OP_WAKE 8'hAB
`define FID_OP_RSTEN 8'h66
`define FID_OP_RST 8'h99
`define FID_OP_MBR 8'hFF
`define FID_OP_QPIEN 8'h38
`define FID_OP_QPIEX 8'hF5
`define FID_PAGE_SIZE 512
`define FID_SECT_BYTES 64
`define FID_MEM_BYTES 256
`define FID_ID_BYTES 16
`define FID_TBL_BYTES 16
`define FID_ADDR_BITS 24
`define FID_DUMMY_CYC 8
`define FID_REL_NS 3000
`define FID_REL_CYC ((`FID_REL_NS + 24) / 25)
`define FID_BUSY_CYC 64
`define FID_DIV 4
// identity and table content; values are arbitrary
`define FID_ID_FIRST 8'h5D
`define FID_ID_BASE 8'h20
`define FID_TBL_KEY 8'h50
`endif

// ==== hw/fid_pkg.sv ====
// types shared by both ends of the flash command link
package fid_pkg;
	typedef enum logic [3:0] {
		FID_S_OP = 4'h0,
		FID_S_ADDR = 4'h1,
		FID_S_DUMMY = 4'h2,
		FID_S_OUT = 4'h3,
		FID_S_DATA = 4'h4,
		FID_S_SKIP = 4'h5
	} fid_dev_st_t;
	typedef enum logic [2:0] {
		FID_H_IDLE = 3'h0,
		FID_H_SEND = 3'h1,
		FID_H_RECV = 3'h2,
		FID_H_WAIT = 3'h3,
		FID_H_DONE = 3'h4
	} fid_host_st_t;
endpackage : fid_pkg

// ==== verification/fid_bench.sv ====
// self-checking bench joining host and device over the link
`timescale 1ns/100ps
`include "fid_params.svh"
module flash_ident_powerdown_cmds_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want = 1'b0;
	logic freeze_in = 1'b0, guard_lock_in = 1'b0, perr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, busy_flag, dsl, flm, xip, frz, sgl;
	logic [7:0] ta;
	logic [31:0] id_exp, tbl_exp;
	logic [63:0] note;
	int n_errors = 0, checks = 0, seed = 51;
	logic [63:0] notes [$];
	fid_link_if link ();
	always #12.5 pclk = ~pclk;
	fid_host #(.DIV(4)) i_fid_host (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	// long busy time so commands can land while an operation runs
	fid_device #(.REL_CYC(20), .BUSY_CYC(600)) i_fid_device (.pclk(pclk), .presetn(presetn),
		.clk_en(1'b1), .link(link), .freeze_in(freeze_in), .guard_lock_in(guard_lock_in),
		.write_in_progress(busy_flag), .deep_sleep(dsl), .four_line_mode(flm), .xip_mode(xip),
		.freeze(frz), .sector_guard_lock(sgl));
	fid_link_checker i_fid_link_checker (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
		.sck(link.sck), .h_io_oe_n(link.h_io_oe_n), .d_io_oe_n(link.d_io_oe_n),
		.write_in_progress(busy_flag), .deep_sleep(dsl), .four_line_mode(flm));
	task automatic test_done;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit
	// one transfer: setup, then access until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		notes.push_back({m, exp});
		// non-blocking so the monitor at this edge still sees the old flag
		want <= 1'b1;
		apb(1'b0, a, 32'h0);
		want <= 1'b0;
	endtask : rd_chk
	// load tx word and counts, start, then poll status until idle
	task automatic run(input logic [7:0] op, input logic quad, input logic [7:0] ntx,
		input logic [7:0] nrx, input logic [31:0] tx);
		apb(1'b1, 8'h04, tx);
		apb(1'b1, 8'h08, {16'h0000, nrx, ntx});
		apb(1'b1, 8'h00, {22'h000000, quad, 1'b1, op});
		for (int i = 0; i < 400; i++) begin
			apb(1'b0, 8'h10, 32'h0);
			if (rd[0] === 1'b0) break;
		end
	endtask : run
	// checked reads complete here against the oldest note, masked bits only
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && want) begin
			checks++;
			note = notes.pop_front();
			if (((prdata ^ note[31:0]) & note[63:32]) !== 32'h0) begin
				n_errors++;
				$display("[FAIL] %0t read %h expected %h", $time, prdata, note[31:0]);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		test_done;
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		cmp_bit(dsl, 1'b0);
		cmp_bit(busy_flag, 1'b0);
		id_exp = {16'h0000, `FID_ID_FIRST, 8'(`FID_ID_BASE + 8'h01)};
		apb(1'b1, 8'hFC, 32'h0);
		cmp_bit(perr, 1'b1);
		// quad ident is not decoded in single-line mode: line stays pulled high
		run(`FID_OP_QIDENT, 1'b0, 8'h08, 8'h10, 32'h0);
		rd_chk(8'h0C, 32'h0000FFFF, 32'h0000FFFF);
		run(`FID_OP_QPIEN, 1'b0, 8'h08, 8'h00, 32'h0);
		cmp_bit(flm, 1'b1);
		// in four-line mode the quad ident returns the stream a nibble per clock
		run(`FID_OP_QIDENT, 1'b1, 8'h08, 8'h10, 32'h0);
		rd_chk(8'h0C, id_exp, 32'h0000FFFF);
		freeze_in <= 1'b1;
		guard_lock_in <= 1'b1;
		@(posedge pclk);
		freeze_in <= 1'b0;
		guard_lock_in <= 1'b0;
		run(`FID_OP_RSTEN, 1'b1, 8'h08, 8'h00, 32'h0);
		run(`FID_OP_RST, 1'b1, 8'h08, 8'h00, 32'h0);
		cmp_bit(flm, 1'b0);
		cmp_bit(frz, 1'b1);
		cmp_bit(sgl, 1'b1);
		// single-line ident: manufacturer byte first, then the next stream byte
		run(`FID_OP_IDENT, 1'b0, 8'h08, 8'h10, 32'h0);
		rd_chk(8'h0C, id_exp, 32'h0000FFFF);
		// table read from a random start address: op, 24 address bits, 8 dummies
		ta = 8'($random(seed));
		tbl_exp = {16'h0000, ta ^ `FID_TBL_KEY, 8'(ta + 8'h01) ^ `FID_TBL_KEY};
		run(`FID_OP_SFDP, 1'b0, 8'd40, 8'h10, {16'h0000, ta, 8'h00});
		rd_chk(8'h0C, tbl_exp, 32'h0000FFFF);
		run(`FID_OP_WR_ON, 1'b0, 8'h08, 8'h00, 32'h0);
		run(`FID_OP_PROG, 1'b0, 8'd40, 8'h00, {16'h0000, 8'($random(seed)), 8'h00});
		cmp_bit(busy_flag, 1'b1);
		run(`FID_OP_SLEEP, 1'b0, 8'h08, 8'h00, 32'h0);
		cmp_bit(dsl, 1'b0);
		run(`FID_OP_IDENT, 1'b0, 8'h08, 8'h10, 32'h0);
		rd_chk(8'h0C, 32'h0000FFFF, 32'h0000FFFF);
		for (int i = 0; i < 1000 && busy_flag !== 1'b0; i++) @(posedge pclk);
		cmp_bit(busy_flag, 1'b0);
		run(`FID_OP_SLEEP, 1'b0, 8'h08, 8'h00, 32'h0);
		cmp_bit(dsl, 1'b1);
		run(`FID_OP_IDENT, 1'b0, 8'h08, 8'h10, 32'h0);
		rd_chk(8'h0C, 32'h0000FFFF, 32'h0000FFFF);
		run(`FID_OP_QPIEN, 1'b0, 8'h08, 8'h00, 32'h0);
		cmp_bit(flm, 1'b0);
		run(`FID_OP_WAKE, 1'b0, 8'h08, 8'h00, 32'h0);
		// release delay is 20 cycles in this bench, plus margin for the edge sync
		repeat (26) @(posedge pclk);
		cmp_bit(dsl, 1'b0);
		test_done;
	end
endmodule : flash_ident_powerdown_cmds_bench

// ==== verification/fid_link_checker.sv ====
// assertions watching the serial link between host and device
`timescale 1ns/100ps
module fid_link_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] h_io_oe_n,
	input wire logic [3:0] d_io_oe_n,
	input wire logic write_in_progress,
	input wire logic deep_sleep,
	input wire logic four_line_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// sck rests low between frames, else the device would count a stray edge
	property p_sck_idle; cs_n && $past(cs_n) |-> !sck; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("sck moved outside a frame");
	// both ends driving one line would fight
	property p_no_clash; (~h_io_oe_n & ~d_io_oe_n) == 4'h0; endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive one line");
	property p_sleep_idle; $rose(deep_sleep) |-> !$past(write_in_progress); endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("sleep entered while busy");
	property p_sleep_entry; $rose(deep_sleep) |-> cs_n; endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered in a frame");
	property p_sleep_quiet; $rose(write_in_progress) |-> !$past(deep_sleep); endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("operation began asleep");
	property p_busy_hold; $rose(write_in_progress) |-> write_in_progress [*8]; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped early");
	// bound sized for the bench's longer operation time
	property p_busy_end; $rose(write_in_progress) |-> ##[1:1000] !write_in_progress; endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy flag never cleared");
	// two sync stages plus the output register: released three clocks after the rise
	property p_cs_abandon; $rose(cs_n) |-> ##[0:3] (&d_io_oe_n); endproperty
	a_cs_abandon: assert property (p_cs_abandon) else $error("device kept driving");
	property p_single_line; !four_line_mode |-> (d_io_oe_n & 4'hD) == 4'hD; endproperty
	a_single_line: assert property (p_single_line) else $error("wrong output line");
endmodule : fid_link_checker
